// *** common/flash_host_cfg.svh ***
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// ----------------------------------------
// timing, as printed
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define LOAD_GAP_US 150
`define WRITE_CYCLE_MS 10
`define POWER_ON_MS 5
`define GLITCH_NS 15
// access time for a read, in ns
`define READ_ACCESS_NS 70

// ----------------------------------------
// derived cycle counts
// ----------------------------------------
// longest gap rounds down; keep a margin of one cycle
`define LOAD_GAP_CYC ((`LOAD_GAP_US * 1000) / `CLK_PERIOD_NS - 1)
`define WRITE_CYCLE_CYC ((`WRITE_CYCLE_MS * 1000000) / `CLK_PERIOD_NS)
`define POWER_ON_CYC ((`POWER_ON_MS * 1000000) / `CLK_PERIOD_NS)
// strobe low time: least time, round up, plus one so it clears the filter
`define STROBE_CYC ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define READ_CYC ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)

// ----------------------------------------
// geometry and codes
// ----------------------------------------
`define ADDR_W 17
`define SECTOR_BYTES 128
`define BYTE_IDX_W 7
`define SECTOR_W 10
`define BIT_SEVEN 7
`define BIT_SIX 6
`define CNT_W 24
// protection command addresses and data
`define PROT_ADDR_0 17'h05555
`define PROT_ADDR_1 17'h02AAA
`define PROT_DATA_0 8'hAA
`define PROT_DATA_1 8'h55
`define PROT_DATA_EN 8'hA0

`endif

// *** common/flash_host_pkg.sv ***
package flash_host_pkg;
    typedef enum {
        ST_IDLE,
        ST_PRE_SETUP,
        ST_PRE_STROBE,
        ST_PRE_GAP,
        ST_LOAD_SETUP,
        ST_LOAD_STROBE,
        ST_LOAD_GAP,
        ST_WAIT_CLOSE,
        ST_POLL_READ,
        ST_POLL_GAP,
        ST_READ,
        ST_DONE
    } host_state_e;
endpackage

// *** src/strobe_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
// ----------------------------------------
// down counter with load and zero flag
// ----------------------------------------
module strobe_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [`CNT_W-1:0] value,
    output logic zero
);
    logic [`CNT_W-1:0] count;

    // reset wins over load, load wins over counting down to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= '0;
        end else if (load) begin
            count <= value;
        end else if (count != '0) begin
            count <= count - `CNT_W'(1);
        end
    end

    assign zero = (count == '0);
endmodule
`default_nettype wire

// *** src/flash_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_host
    import flash_host_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic READ_REQ,
    input wire logic PROG_REQ,
    input wire logic PROTECT,
    input wire logic [`ADDR_W-1:0] REQ_ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_VALID,
    output logic WR_READY,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic BUSY,
    output logic DONE,
    output logic TIMEOUT,
    output logic [`ADDR_W-1:0] FLASH_ADDR,
    output logic FLASH_CE_N,
    output logic FLASH_OE_N,
    output logic FLASH_WE_N,
    input wire logic [7:0] FLASH_DQ_IN,
    output logic [7:0] FLASH_DQ_OUT,
    output logic FLASH_DQ_OE
);
    typedef struct packed {
        host_state_e state;
        logic [`ADDR_W-1:0] addr;
        logic [`ADDR_W-1:0] pin_addr;
        logic [7:0] dout;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [1:0] pre_idx;
        logic [`BYTE_IDX_W:0] byte_cnt;
        logic [7:0] last_data;
        logic [7:0] rd_data;
        logic rd_valid;
        logic wr_ready;
        logic busy;
        logic done;
        logic timeout;
        logic pwr_ok;
        logic [`CNT_W-1:0] deadline;
    } state_s;

    state_s cur;
    state_s next_cur;
    logic tload;
    logic [`CNT_W-1:0] tvalue;
    logic tzero;
    logic [`ADDR_W-1:0] pre_addr;
    logic [7:0] pre_data;

    // shared timer for strobe width and access time; its own reset overrides the power-on lockout load
    strobe_timer u_timer (
        .clk(CORE_CLK),
        .srst(SRST),
        .load(tload),
        .value(tvalue),
        .zero(tzero)
    );

    // protection prefix word for each step
    always_comb begin
        case (cur.pre_idx)
            2'h0: begin
                pre_addr = `PROT_ADDR_0;
                pre_data = `PROT_DATA_0;
            end
            2'h1: begin
                pre_addr = `PROT_ADDR_1;
                pre_data = `PROT_DATA_1;
            end
            default: begin
                pre_addr = `PROT_ADDR_0;
                pre_data = `PROT_DATA_EN;
            end
        endcase
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_cur = cur;
        tload = 1'b0;
        tvalue = '0;
        next_cur.rd_valid = 1'b0;
        next_cur.done = 1'b0;
        next_cur.wr_ready = 1'b0;
        if (cur.deadline != '0) begin
            next_cur.deadline = cur.deadline - `CNT_W'(1);
        end
        case (cur.state)
            ST_IDLE: begin
                next_cur.busy = 1'b0;
                next_cur.ce_n = 1'b1;
                next_cur.oe_n = 1'b1;
                next_cur.we_n = 1'b1;
                next_cur.dq_oe = 1'b0;
                if (!cur.pwr_ok) begin
                    // power-on wait: reset holds the timer at zero, so tzero ends this wait after one cycle
                    if (tzero) begin
                        next_cur.pwr_ok = 1'b1;
                    end
                end else if (READ_REQ) begin
                    next_cur.busy = 1'b1;
                    next_cur.addr = REQ_ADDR;
                    next_cur.pin_addr = REQ_ADDR;
                    next_cur.ce_n = 1'b0;
                    next_cur.oe_n = 1'b0;
                    tload = 1'b1;
                    tvalue = `CNT_W'(`READ_CYC);
                    next_cur.state = ST_READ;
                end else if (PROG_REQ) begin
                    next_cur.busy = 1'b1;
                    // sector is fixed from here on, byte index counts loads
                    next_cur.addr = {REQ_ADDR[`ADDR_W-1:`BYTE_IDX_W], {`BYTE_IDX_W{1'b0}}};
                    // pins settle at least one cycle before the first strobe falls
                    next_cur.pin_addr = next_cur.addr;
                    if (PROTECT) begin
                        next_cur.pin_addr = `PROT_ADDR_0;
                    end
                    next_cur.byte_cnt = '0;
                    next_cur.pre_idx = 2'h0;
                    next_cur.timeout = 1'b0;
                    next_cur.state = PROTECT ? ST_PRE_SETUP : ST_LOAD_SETUP;
                end
            end
            ST_PRE_SETUP: begin
                // command prefix, same load timing as data
                next_cur.oe_n = 1'b1;
                next_cur.ce_n = 1'b0;
                next_cur.dq_oe = 1'b1;
                next_cur.dout = pre_data;
                next_cur.state = ST_PRE_STROBE;
                tload = 1'b1;
                tvalue = `CNT_W'(`STROBE_CYC);
                next_cur.we_n = 1'b0;
            end
            ST_PRE_STROBE: begin
                if (tzero) begin
                    next_cur.we_n = 1'b1;
                    next_cur.pre_idx = cur.pre_idx + 2'h1;
                    next_cur.state = ST_PRE_GAP;
                end
            end
            ST_PRE_GAP: begin
                next_cur.ce_n = 1'b1;
                next_cur.pin_addr = (cur.pre_idx == 2'h3) ? cur.addr : pre_addr;
                next_cur.state = (cur.pre_idx == 2'h3) ? ST_LOAD_SETUP : ST_PRE_SETUP;
            end
            ST_LOAD_SETUP: begin
                next_cur.ce_n = 1'b1;
                next_cur.we_n = 1'b1;
                next_cur.wr_ready = 1'b1;
                if (WR_VALID && cur.wr_ready) begin
                    next_cur.wr_ready = 1'b0;
                    next_cur.dout = WR_DATA;
                    next_cur.last_data = WR_DATA;
                    next_cur.dq_oe = 1'b1;
                    next_cur.oe_n = 1'b1;
                    next_cur.ce_n = 1'b0;
                    next_cur.we_n = 1'b0;
                    tload = 1'b1;
                    tvalue = `CNT_W'(`STROBE_CYC);
                    next_cur.state = ST_LOAD_STROBE;
                end else if (cur.byte_cnt != '0 && cur.deadline == '0) begin
                    // the device closed the load period early
                    next_cur.timeout = 1'b1;
                    next_cur.wr_ready = 1'b0;
                    // poll the last byte actually loaded
                    next_cur.pin_addr[`BYTE_IDX_W-1:0] =
                        cur.byte_cnt[`BYTE_IDX_W-1:0] - `BYTE_IDX_W'(1);
                    next_cur.deadline = `CNT_W'(`WRITE_CYCLE_CYC);
                    next_cur.state = ST_POLL_READ;
                end
            end
            ST_LOAD_STROBE: begin
                if (tzero) begin
                    next_cur.we_n = 1'b1;
                    next_cur.byte_cnt = cur.byte_cnt + 8'h01;
                    next_cur.deadline = `CNT_W'(`LOAD_GAP_CYC);
                    next_cur.state = ST_LOAD_GAP;
                end
            end
            ST_LOAD_GAP: begin
                next_cur.ce_n = 1'b1;
                next_cur.dq_oe = 1'b0;
                if (cur.byte_cnt == 8'(`SECTOR_BYTES)) begin
                    next_cur.state = ST_WAIT_CLOSE;
                end else begin
                    next_cur.addr[`BYTE_IDX_W-1:0] = cur.byte_cnt[`BYTE_IDX_W-1:0];
                    next_cur.pin_addr[`BYTE_IDX_W-1:0] = cur.byte_cnt[`BYTE_IDX_W-1:0];
                    next_cur.state = ST_LOAD_SETUP;
                end
            end
            ST_WAIT_CLOSE: begin
                // silence lets the device start its own cycle
                if (cur.deadline == '0) begin
                    next_cur.deadline = `CNT_W'(`WRITE_CYCLE_CYC);
                    next_cur.state = ST_POLL_READ;
                end
            end
            ST_POLL_READ: begin
                next_cur.ce_n = 1'b0;
                next_cur.oe_n = 1'b0;
                tload = 1'b1;
                tvalue = `CNT_W'(`READ_CYC);
                next_cur.state = ST_POLL_GAP;
            end
            ST_POLL_GAP: begin
                if (tzero) begin
                    next_cur.ce_n = 1'b1;
                    next_cur.oe_n = 1'b1;
                    if (FLASH_DQ_IN[`BIT_SEVEN] == cur.last_data[`BIT_SEVEN]) begin
                        next_cur.done = 1'b1;
                        next_cur.state = ST_DONE;
                    end else if (cur.deadline == '0) begin
                        next_cur.timeout = 1'b1;
                        next_cur.done = 1'b1;
                        next_cur.state = ST_DONE;
                    end else begin
                        next_cur.state = ST_POLL_READ;
                    end
                end
            end
            ST_READ: begin
                if (tzero) begin
                    next_cur.rd_data = FLASH_DQ_IN;
                    next_cur.rd_valid = 1'b1;
                    next_cur.ce_n = 1'b1;
                    next_cur.oe_n = 1'b1;
                    next_cur.state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_cur.busy = 1'b0;
                next_cur.state = ST_IDLE;
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
        if (SRST) begin
            next_cur = '0;
            next_cur.state = ST_IDLE;
            next_cur.ce_n = 1'b1;
            next_cur.oe_n = 1'b1;
            next_cur.we_n = 1'b1;
            tload = 1'b1;
            tvalue = `CNT_W'(`POWER_ON_CYC);
        end
    end

    // register the whole state
    always_ff @(posedge CORE_CLK) begin
        cur <= next_cur;
    end

    // ----------------------------------------
    // outputs straight from flops
    // ----------------------------------------
    assign FLASH_ADDR = cur.pin_addr;
    assign FLASH_CE_N = cur.ce_n;
    assign FLASH_OE_N = cur.oe_n;
    assign FLASH_WE_N = cur.we_n;
    assign FLASH_DQ_OUT = cur.dout;
    assign FLASH_DQ_OE = cur.dq_oe;
    assign WR_READY = cur.wr_ready;
    assign RD_DATA = cur.rd_data;
    assign RD_VALID = cur.rd_valid;
    assign BUSY = cur.busy;
    assign DONE = cur.done;
    assign TIMEOUT = cur.timeout;
endmodule
`default_nettype wire

// *** bench/flash_host_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
// ----------------------------------------
// port checker for the flash host
// ----------------------------------------
module flash_host_checker (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic READ_REQ,
    input wire logic PROG_REQ,
    input wire logic PROTECT,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic RD_VALID,
    input wire logic WR_READY,
    input wire logic [`ADDR_W-1:0] FLASH_ADDR,
    input wire logic FLASH_CE_N,
    input wire logic FLASH_OE_N,
    input wire logic FLASH_WE_N,
    input wire logic [7:0] FLASH_DQ_OUT,
    input wire logic FLASH_DQ_OE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // protected start, then the opening command strobe
    sequence prot_start;
        $rose(BUSY) && $past(PROG_REQ && PROTECT && !READ_REQ);
    endsequence
    sequence first_cmd;
        ##[1:30] ($fell(FLASH_WE_N) && FLASH_ADDR == 17'h05555 && FLASH_DQ_OUT == 8'hAA);
    endsequence
    a_prefix_first: assert property (prot_start |-> first_cmd)
        else $error("protected program lacks opening command");
    a_read_strobes: assert property ($fell(FLASH_OE_N) |-> FLASH_WE_N && !FLASH_CE_N)
        else $error("read started with bad strobes");
    a_oe_no_drive: assert property (!FLASH_OE_N |-> !FLASH_DQ_OE)
        else $error("host drives data during read");
    a_load_oe_high: assert property (!FLASH_WE_N |-> FLASH_OE_N && FLASH_DQ_OE)
        else $error("byte load without output disable or data");
    a_strobe_width: assert property ($fell(FLASH_WE_N) |-> !FLASH_WE_N [*2])
        else $error("write strobe too short");
    a_load_hold: assert property (!FLASH_WE_N && $past(!FLASH_WE_N) |->
        $stable(FLASH_ADDR) && $stable(FLASH_DQ_OUT))
        else $error("address or data moved under strobe");
    a_done_pulse: assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");
    a_ready_busy: assert property (WR_READY |-> BUSY && FLASH_OE_N)
        else $error("ready outside program");
    a_idle_quiet: assert property (!BUSY && !$past(BUSY) |->
        FLASH_CE_N && FLASH_OE_N && FLASH_WE_N)
        else $error("strobe active while idle");
    a_read_answer: assert property ($rose(BUSY) && $past(READ_REQ) |-> ##[6:14] RD_VALID)
        else $error("read answer late");
endmodule
bind flash_host flash_host_checker chk_u (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .READ_REQ(READ_REQ), .PROG_REQ(PROG_REQ),
    .PROTECT(PROTECT), .BUSY(BUSY), .DONE(DONE), .RD_VALID(RD_VALID), .WR_READY(WR_READY),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_CE_N(FLASH_CE_N), .FLASH_OE_N(FLASH_OE_N),
    .FLASH_WE_N(FLASH_WE_N), .FLASH_DQ_OUT(FLASH_DQ_OUT), .FLASH_DQ_OE(FLASH_DQ_OE));
`default_nettype wire

// *** bench/flash_device_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// behavioural sector flash
// ----------------------------------------
module flash_device_model #(
    parameter int PROG_NS = 100000,
    parameter int POWER_NS = 5000000
) (
    input wire logic [16:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem [0:131071];
    logic [7:0] sbuf [0:127];
    logic [127:0] got;
    logic [9:0] sect;
    logic [16:0] la;
    logic [7:0] ld_last, last, rd_val;
    logic prot, busy, tgl;
    int step, seq;
    realtime tf;
    wire wl;
    wire rd_now;
    wire rd_late;
    // strobe decode; released bus shows inverse of last value
    assign wl = !ce_n && !we_n && oe_n;
    assign rd_now = !ce_n && !oe_n && we_n;
    assign #70 rd_late = rd_now;
    assign rd_val = busy ? {~ld_last[7], tgl, ld_last[5:0]} : mem[addr];
    assign dq_o = (rd_now && rd_late) ? rd_val : ~last;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        prot = 1'b0;
        busy = 1'b0;
        tgl = 1'b0;
        step = 0;
        seq = 0;
        got = '0;
        last = 8'h00;
        ld_last = 8'h00;
        tf = 0;
    end
    // bus history and toggle bit
    always @(negedge rd_now) last = rd_val;
    always @(negedge oe_n) if (busy) tgl = ~tgl;
    // byte load: address on later fall, data on first rise
    always @(posedge wl) begin
        la = addr;
        tf = $realtime;
    end
    always @(negedge wl) begin
        if ($realtime - tf >= 15.0 && !busy) begin
            take(la, dq_i);
            seq++;
            fork
                close(seq);
            join_none
        end
    end
    task automatic take(input logic [16:0] a, input logic [7:0] d);
        if (step == 0 && a == 17'h05555 && d == 8'hAA) step = 1;
        else if (step == 1 && a == 17'h02AAA && d == 8'h55) step = 2;
        else if (step == 2 && a == 17'h05555 && d == 8'hA0) begin
            step = 3;
            prot = 1'b1;
        end else begin
            sbuf[a[6:0]] = d;
            got[a[6:0]] = 1'b1;
            sect = a[16:7];
            ld_last = d;
        end
    endtask
    // silence ends the load; latched bytes written after the timer
    task automatic close(input int s);
        logic ok;
        #150000;
        if (s != seq || busy) return;
        ok = (!prot || step == 3) && $realtime >= POWER_NS;
        busy = 1'b1;
        #(PROG_NS);
        for (int i = 0; i < 128; i++) begin
            if (ok && got[i]) mem[{sect, i[6:0]}] = sbuf[i];
        end
        got = '0;
        step = 0;
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module testbench import flash_host_pkg::*;;
    logic core_clk, srst, read_req, prog_req, protect, wr_valid;
    logic wr_ready, rd_valid, busy, done, timeout, ce_n, oe_n, we_n, dq_oe;
    logic [16:0] req_addr, f_addr;
    logic [7:0] wr_data, rd_data, dq_in, dq_out, dev_dq;
    logic [2:0] v;
    int failures = 0;
    int checks_done = 0;
    // ----------------------------------------
    // block, device and shared data bus
    // ----------------------------------------
    flash_host dut_u (.CORE_CLK(core_clk), .SRST(srst), .READ_REQ(read_req),
        .PROG_REQ(prog_req), .PROTECT(protect), .REQ_ADDR(req_addr), .WR_DATA(wr_data),
        .WR_VALID(wr_valid), .WR_READY(wr_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .BUSY(busy), .DONE(done), .TIMEOUT(timeout), .FLASH_ADDR(f_addr),
        .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .FLASH_DQ_IN(dq_in),
        .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe));
    flash_device_model dev_u (.addr(f_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .dq_i(dq_in), .dq_o(dev_dq));
    assign dq_in = dq_oe ? dq_out : dev_dq;
    assign v = {rd_valid, done, wr_ready};
    // clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_hi(input int k, input int lim);
        int n;
        n = 0;
        while (v[k] !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        `CHK(v[k], 1'b1)
    endtask
    task automatic rd(input logic [16:0] a, input logic [7:0] exp);
        req_addr = a;
        read_req = 1'b1;
        tick(1);
        read_req = 1'b0;
        wait_hi(2, 50);
        `CHK(rd_data, exp)
        tick(2);
        `CHK(busy, 1'b0)
    endtask
    // bytes base^i at offset i; short settle after done
    task automatic prog(input logic [9:0] sec, input logic p, input logic [7:0] base,
        input int nb, input logic exp_to);
        protect = p;
        req_addr = {sec, 7'h00};
        prog_req = 1'b1;
        tick(1);
        prog_req = 1'b0;
        `CHK(busy, 1'b1)
        for (int i = 0; i < nb; i++) begin
            wr_data = base ^ i[7:0];
            wr_valid = 1'b1;
            wait_hi(0, 100);
            tick(1);
        end
        wr_valid = 1'b0;
        wait_hi(1, 300000);
        `CHK(timeout, exp_to)
        tick(2);
        `CHK(busy, 1'b0)
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        `CHK({ce_n, oe_n, we_n, dq_oe, busy}, 5'b11100)
        read_req = 1'b1;
        tick(1);
        read_req = 1'b0;
        tick(3);
        `CHK(busy, 1'b0)
        $display("reset test done");
    endtask
    task automatic t_plain();
        rd(17'h00185, 8'hFF);
        prog(10'd3, 1'b0, 8'h3C, 128, 1'b0);
        rd({10'd3, 7'h00}, 8'h3C);
        rd({10'd3, 7'h40}, 8'h7C);
        rd({10'd3, 7'h7F}, 8'h43);
        rd({10'd2, 7'h7F}, 8'hFF);
        $display("plain program test done");
    endtask
    task automatic t_guard();
        prog(10'd4, 1'b1, 8'h21, 128, 1'b0);
        rd({10'd4, 7'h05}, 8'h24);
        prog(10'd4, 1'b0, 8'h20, 128, 1'b0);
        rd({10'd4, 7'h05}, 8'h24);
        $display("protection test done");
    endtask
    task automatic t_gap();
        prog(10'd5, 1'b1, 8'h10, 5, 1'b1);
        $display("gap test done");
    endtask
    // main sequence
    initial begin
        srst = 1'b1;
        {read_req, prog_req, protect, wr_valid} = 4'h0;
        req_addr = 17'h00000;
        wr_data = 8'h00;
        tick(10);
        srst = 1'b0;
        t_reset();
        tick(`POWER_ON_CYC);
        t_plain();
        t_guard();
        t_gap();
        summarize();
    end
    // watchdog: power-on wait plus four sector programs, with margin
    initial begin
        #8000000;
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
